//--- pkg/tkc_cfg.svh
/*
  Offsets, bit positions, reset values and counter limits of the touch key
  control block. Assumes an 8-bit register port with a 2-bit address.
*/
`ifndef TKC_CFG_SVH
`define TKC_CFG_SVH

`define TKC_ADDR_W      2
`define TKC_OFS_SWITCH  2'h0
`define TKC_OFS_START   2'h1
`define TKC_OFS_PADFN   2'h2

`define TKC_RST_SWITCH  8'h00
`define TKC_RST_START   8'h00
`define TKC_RST_PADFN   8'h00

`define TKC_B_KSEL      0
`define TKC_B_SDBL      2
`define TKC_B_PER       3
`define TKC_B_RCLR      5
`define TKC_B_SOSC      6
`define TKC_B_ROSC      7

`define TKC_B_START     0
`define TKC_B_OVF       1
`define TKC_B_REFPAD    2

`define TKC_LAST_512    12'h1ff
`define TKC_LAST_1024   12'h3ff
`define TKC_LAST_2048   12'h7ff
`define TKC_LAST_4096   12'hfff

`endif

//--- pkg/tkc_pkg.sv
/*
  Types and shared decode functions of the touch key control block.
  Assumes tkc_cfg.svh is on the include path.
*/
`include "tkc_cfg.svh"

package tkc_pkg;

  typedef logic [7:0]  tkc_byte_t;
  typedef logic [11:0] tkc_count_t;

  typedef enum logic [2:0] {
    TKC_IDLE = 3'b001,
    TKC_RUN  = 3'b010,
    TKC_DONE = 3'b100
  } tkc_state_t;

  // Last count value before the reference counter rolls over
  function automatic tkc_count_t tkc_last(input logic [1:0] per);
    case (per)
      2'h0:    tkc_last = `TKC_LAST_512;
      2'h1:    tkc_last = `TKC_LAST_1024;
      2'h2:    tkc_last = `TKC_LAST_2048;
      default: tkc_last = `TKC_LAST_4096;
    endcase
  endfunction

  function automatic logic [3:0] tkc_key_dec(input logic [1:0] sel);
    tkc_key_dec = 4'h1 << sel;
  endfunction

endpackage

//--- pkg/tkc_if.sv
/*
  Link between the touch key controller and its reference counter.
  Assumes both ends share clk_i and sys_rst_i.
*/
`timescale 1ns/100ps

interface tkc_if;
  import tkc_pkg::*;
  logic       clr;
  logic       run;
  logic       tick;
  logic [1:0] per;
  tkc_count_t count;
  logic       wrap;

  modport ctl (output clr, run, tick, per, input count, wrap);
  modport cnt (input clr, run, tick, per, output count, wrap);
endinterface

//--- design/tkc_sync.sv
/*
  Two-stage synchroniser with edge pulses for an oscillator clock pin.
  Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/100ps

module tkc_sync (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  output wire logic rise_o,
  output wire logic fall_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign rise_o = s2_reg & ~s3_reg;
  assign fall_o = ~s2_reg & s3_reg;

endmodule

//--- design/tkc_refcnt.sv
/*
  12-bit reference counter with selectable rollover point.
  Assumes tick is a one-cycle pulse per synchronised reference clock.
*/
`timescale 1ns/100ps

module tkc_refcnt
  import tkc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  tkc_if.cnt        cif
);

  tkc_count_t count_reg;
  logic       at_last;

  assign at_last  = cif.run && cif.tick && (count_reg == tkc_last(cif.per));
  assign cif.wrap = at_last && !cif.clr;
  assign cif.count = count_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_reg <= 12'h000;
    end else if (cif.clr) begin
      count_reg <= 12'h000;
    end else if (cif.run && cif.tick) begin
      count_reg <= at_last ? 12'h000 : count_reg + 12'h001;
    end
  end

  a_count_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !cif.run && !cif.clr |=> $stable(count_reg))
    else $error("Reference count moved while stopped");

endmodule

//--- design/tkc_top.sv
/*
  Touch key control: register file, pad switch steering, reference period
  measurement and sensor clock gating toward an external timer.
  Assumes oscillator clocks arrive asynchronously on pins and a register
  master with one-cycle strobes and read data one cycle later.
*/
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "tkc_cfg.svh"

module tkc_top
  import tkc_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [`TKC_ADDR_W-1:0] addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic                   raw_sensor_osc_clk_i,
  input  wire logic                   reference_osc_clk_i,
  output logic                        sensor_osc_on_o,
  output logic                        reference_osc_on_o,
  output logic      [3:0]             pad_series_switch_o,
  output logic      [3:0]             pad_ground_switch_o,
  output logic      [3:0]             pad_digital_off_o,
  output logic                        reference_pad_switch_o,
  output logic                        reference_pad_digital_off_o,
  output logic                        reference_clock_o,
  output logic                        sensor_clock_o,
  output logic                        gated_sensor_clock_o,
  output logic                        touch_irq_o
);

  localparam tkc_byte_t RST_START = `TKC_RST_START;
  localparam tkc_byte_t RST_PADFN = `TKC_RST_PADFN;

  tkc_byte_t  switch_reg;
  logic       start_bit_reg;
  logic       reference_pad_select_reg;
  logic [3:0] padfn_reg;
  logic       overflow_flag_reg;
  logic       start_prev_reg;
  logic       clear_prev_reg;
  logic       sync_en_reg;
  tkc_state_t state_reg;
  tkc_state_t state_next;
  tkc_byte_t  rdata_reg;
  logic [3:0] series_reg;
  logic [3:0] ground_reg;
  logic [3:0] digital_off_reg;
  logic       ref_switch_reg;
  logic       ref_digital_off_reg;
  logic       sensor_on_reg;
  logic       reference_on_reg;
  logic       ref_clk_reg;
  logic       sens_clk_reg;
  logic       gated_clk_reg;
  logic       irq_reg;

  logic       start_rise;
  logic       clear_rise;
  logic       start_accept;
  logic       ref_rise;
  logic       sens_rise;
  logic       sens_fall;
  logic       sens_tick;
  logic [1:0] key_select;
  logic       sensor_clock_double;
  logic [1:0] period_select;
  logic       refcount_clear;
  tkc_byte_t  read_mux;

  tkc_if cif ();

  assign key_select          = switch_reg[`TKC_B_KSEL +: 2];
  assign sensor_clock_double = switch_reg[`TKC_B_SDBL];
  assign period_select       = switch_reg[`TKC_B_PER +: 2];
  assign refcount_clear      = switch_reg[`TKC_B_RCLR];

  // Register writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      switch_reg               <= `TKC_RST_SWITCH;
      start_bit_reg            <= RST_START[`TKC_B_START];
      reference_pad_select_reg <= RST_START[`TKC_B_REFPAD];
      padfn_reg                <= RST_PADFN[3:0];
    end else if (wr_i) begin
      case (addr_i)
        `TKC_OFS_SWITCH: begin
          switch_reg <= wdata_i;
        end
        `TKC_OFS_START: begin
          start_bit_reg            <= wdata_i[`TKC_B_START];
          reference_pad_select_reg <= wdata_i[`TKC_B_REFPAD];
        end
        `TKC_OFS_PADFN: begin
          padfn_reg <= wdata_i[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read path, zero outside the cycle after a read strobe
  always_comb begin
    case (addr_i)
      `TKC_OFS_SWITCH: read_mux = switch_reg;
      `TKC_OFS_START:  read_mux = {5'h00, reference_pad_select_reg,
                                   overflow_flag_reg, start_bit_reg};
      `TKC_OFS_PADFN:  read_mux = {4'h0, padfn_reg};
      default:         read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rd_i ? read_mux : 8'h00;
    end
  end

  // Control bit edge detection
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      start_prev_reg <= 1'b0;
      clear_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_bit_reg;
      clear_prev_reg <= refcount_clear;
    end
  end

  assign start_rise   = start_bit_reg & ~start_prev_reg;
  assign clear_rise   = refcount_clear & ~clear_prev_reg;
  assign start_accept = start_rise && (state_reg != TKC_RUN);

  // Oscillator clock synchronisers
  tkc_sync u_ref_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (reference_osc_clk_i),
    .rise_o    (ref_rise),
    .fall_o    ()
  );

  tkc_sync u_sens_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (raw_sensor_osc_clk_i),
    .rise_o    (sens_rise),
    .fall_o    (sens_fall)
  );

  // Doubled rate counts both edges of the raw oscillator
  assign sens_tick = sensor_clock_double ? (sens_rise | sens_fall)
                                         : sens_rise;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_en_reg <= 1'b0;
    end else if (start_accept) begin
      sync_en_reg <= 1'b1;
    end
  end

  // Measurement sequencer
  always_comb begin
    case (state_reg)
      TKC_IDLE: state_next = start_accept ? TKC_RUN : TKC_IDLE;
      TKC_RUN:  state_next = cif.wrap ? TKC_DONE : TKC_RUN;
      TKC_DONE: state_next = start_accept ? TKC_RUN : TKC_DONE;
      default:  state_next = TKC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= TKC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cif.clr  = clear_rise;
  assign cif.run  = (state_reg == TKC_RUN);
  assign cif.tick = sync_en_reg & ref_rise;
  assign cif.per  = period_select;

  tkc_refcnt u_refcnt (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .cif       (cif)
  );

  // Overflow flag: set by a counter wrap, cleared by an accepted start rise; register writes to bit 1 are ignored
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (cif.wrap) begin
      overflow_flag_reg <= 1'b1;
    end else if (start_accept) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= cif.wrap;
    end
  end

  // Clock outputs toward the timer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ref_clk_reg   <= 1'b0;
      sens_clk_reg  <= 1'b0;
      gated_clk_reg <= 1'b0;
    end else begin
      ref_clk_reg   <= sync_en_reg & ref_rise;
      sens_clk_reg  <= sync_en_reg & sens_tick;
      gated_clk_reg <= sync_en_reg & sens_tick
                       & (state_next == TKC_RUN);
    end
  end

  // Pad switch and pin function steering
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      series_reg          <= 4'h0;
      ground_reg          <= 4'h0;
      digital_off_reg     <= 4'h0;
      ref_switch_reg      <= 1'b0;
      ref_digital_off_reg <= 1'b0;
    end else begin
      series_reg          <= padfn_reg & tkc_key_dec(key_select);
      ground_reg          <= padfn_reg & ~tkc_key_dec(key_select);
      digital_off_reg     <= padfn_reg;
      ref_switch_reg      <= reference_pad_select_reg;
      ref_digital_off_reg <= reference_pad_select_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sensor_on_reg    <= 1'b0;
      reference_on_reg <= 1'b0;
    end else begin
      sensor_on_reg    <= switch_reg[`TKC_B_SOSC];
      reference_on_reg <= switch_reg[`TKC_B_ROSC];
    end
  end

  assign rdata_o                     = rdata_reg;
  assign sensor_osc_on_o             = sensor_on_reg;
  assign reference_osc_on_o          = reference_on_reg;
  assign pad_series_switch_o         = series_reg;
  assign pad_ground_switch_o         = ground_reg;
  assign pad_digital_off_o           = digital_off_reg;
  assign reference_pad_switch_o      = ref_switch_reg;
  assign reference_pad_digital_off_o = ref_digital_off_reg;
  assign reference_clock_o           = ref_clk_reg;
  assign sensor_clock_o              = sens_clk_reg;
  assign gated_sensor_clock_o        = gated_clk_reg;
  assign touch_irq_o                 = irq_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_key_exclusive: assert property (
    ((pad_series_switch_o & pad_ground_switch_o) == 4'h0)
    && ($countones(pad_series_switch_o) <= 1))
    else $error("Pad series and ground switches overlap");

  a_io_pad_open: assert property (
    ##1 ((pad_series_switch_o | pad_ground_switch_o)
         & ~$past(padfn_reg)) == 4'h0)
    else $error("Switch closed on a general I/O pad");

  a_touch_digital: assert property (
    wr_i && addr_i == `TKC_OFS_PADFN
    |=> ##1 pad_digital_off_o == $past(wdata_i[3:0], 2))
    else $error("Pad digital path not following pad role");

  a_double_rate: assert property (
    sens_fall && sync_en_reg && sensor_clock_double |=> sensor_clock_o)
    else $error("Falling sensor edge not counted in doubled mode");

  a_wrap_point: assert property (
    cif.wrap |-> ({1'b0, cif.count} + 13'h0001)
                 == (13'h0200 << period_select)
    ##1 cif.count == 12'h000)
    else $error("Reference counter rolled at the wrong point");

  a_clear_count: assert property (
    clear_rise |=> cif.count == 12'h000)
    else $error("Counter not cleared by clear rise");

  a_osc_enable: assert property (
    wr_i && addr_i == `TKC_OFS_SWITCH |=> ##1
    sensor_osc_on_o == $past(wdata_i[`TKC_B_SOSC], 2)
    && reference_osc_on_o == $past(wdata_i[`TKC_B_ROSC], 2))
    else $error("Oscillator enable not following register");

  a_start_run: assert property (
    start_accept |=> state_reg == TKC_RUN && sync_en_reg
    && !overflow_flag_reg)
    else $error("Start rise did not begin a measurement");

  a_retrigger: assert property (
    start_rise && state_reg == TKC_RUN && !cif.wrap
    |=> state_reg == TKC_RUN && $stable(overflow_flag_reg))
    else $error("Start retrigger disturbed a running measurement");

  a_ovf_flag: assert property (
    cif.wrap |=> overflow_flag_reg && touch_irq_o ##1 !touch_irq_o)
    else $error("Overflow did not set flag and request");

  a_gate_block: assert property (
    state_reg != TKC_RUN && !start_accept |=> !gated_sensor_clock_o)
    else $error("Gated sensor clock leaked outside a period");

  a_ref_pad: assert property (
    ##1 reference_pad_switch_o == $past(reference_pad_select_reg)
    && reference_pad_digital_off_o == reference_pad_switch_o)
    else $error("Reference pad switch not following select");

  a_reserved_zero: assert property (
    rd_i && addr_i == `TKC_OFS_START |=> rdata_o[7:3] == 5'h00)
    else $error("Unused start register bits read non-zero");

  c_full_period: cover property (state_reg == TKC_RUN ##1 cif.wrap);
  c_retrigger: cover property (start_rise && state_reg == TKC_RUN);
  c_double_gate: cover property (gated_sensor_clock_o
                                 && sensor_clock_double);
  c_clear_run: cover property (clear_rise && state_reg == TKC_RUN);

endmodule

//--- tb/tkc_osc_model.sv
/*
  Behavioural pad oscillators on the far side of the touch key block.
  Assumes the enables come from the block's oscillator-on outputs.
*/
`timescale 1ns/100ps

module tkc_osc_model #(
  parameter real SEN_HALF = 28.0,
  parameter real REF_HALF = 24.0
) (
  input  wire logic sensor_on_i,
  input  wire logic reference_on_i,
  output logic      raw_sensor_osc_clk_o,
  output logic      reference_osc_clk_o
);
  // Disabled oscillator stands low; phases unrelated to system clock
  initial begin
    raw_sensor_osc_clk_o = 1'b0;
    #3.3;
    forever begin
      #(SEN_HALF);
      raw_sensor_osc_clk_o = sensor_on_i & ~raw_sensor_osc_clk_o;
    end
  end

  initial begin
    reference_osc_clk_o = 1'b0;
    #5.1;
    forever begin
      #(REF_HALF);
      reference_osc_clk_o = reference_on_i & ~reference_osc_clk_o;
    end
  end
endmodule

//--- tb/touch_key_control_tb.sv
/*
  Self-checking bench of the touch key control block.
  Assumes tkc_osc_model stands in for the two pad oscillators.
*/
`timescale 1ns/100ps
`include "tkc_cfg.svh"

module touch_key_control_tb;
  logic       clk_i;
  logic       sys_rst_i;
  logic [1:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic [7:0] rdata_o;
  logic       sen_raw, ref_raw, sen_on, ref_on;
  logic [3:0] ser_sw, gnd_sw, dig_off;
  logic       ref_sw, ref_off, ref_clk, sen_clk, gat_clk, irq;
  int         err_count = 0, check_count = 0;
  integer     ref_n = 0, sen_n = 0, gat_n = 0, n0;
  logic [7:0] d, sw, pf;

  tkc_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .raw_sensor_osc_clk_i(sen_raw), .reference_osc_clk_i(ref_raw),
    .sensor_osc_on_o(sen_on), .reference_osc_on_o(ref_on),
    .pad_series_switch_o(ser_sw), .pad_ground_switch_o(gnd_sw),
    .pad_digital_off_o(dig_off), .reference_pad_switch_o(ref_sw),
    .reference_pad_digital_off_o(ref_off), .reference_clock_o(ref_clk),
    .sensor_clock_o(sen_clk), .gated_sensor_clock_o(gat_clk),
    .touch_irq_o(irq));

  tkc_osc_model osc (.sensor_on_i(sen_on), .reference_on_i(ref_on),
    .raw_sensor_osc_clk_o(sen_raw), .reference_osc_clk_o(ref_raw));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Pulse tallies of the three clock outputs
  // Four-state tallies so an unknown pulse output poisons the count
  always @(posedge clk_i) begin
    if (!sys_rst_i) begin
      ref_n <= ref_n + 32'(ref_clk);
      sen_n <= sen_n + 32'(sen_clk);
      gat_n <= gat_n + 32'(gat_clk);
    end
  end

  function automatic logic [3:0] key_sel(input logic [1:0] s);
    return 4'h1 << s;
  endfunction

  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkn(input integer g, input integer e, input integer tol);
    check_count++;
    if ($isunknown(g) || g < e - tol || g > e + tol) begin
      err_count++;
      $display("BAD %0t count %0d expected %0d", $time, g, e);
    end
  endtask

  // One strobe, one idle cycle; read data taken in the cycle after
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [7:0] v);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= w;
    rd_i    <= ~w;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 d = rdata_o;
    @(posedge clk_i);
  endtask

  // mode 1 clears the counter mid-run, mode 2 retriggers start
  task automatic measure(input logic [1:0] per, input int mode);
    integer base, g0, n;
    bit     done;
    n = 512 << per;
    done = 0;
    sw = {2'b11, 1'b0, per, per[1], 2'b01};
    bus(1, `TKC_OFS_SWITCH, sw);
    bus(1, `TKC_OFS_SWITCH, sw | 8'h20);
    bus(1, `TKC_OFS_SWITCH, sw);
    bus(1, `TKC_OFS_START, 8'h04);
    bus(1, `TKC_OFS_START, 8'h05);
    base = ref_n;
    g0 = gat_n;
    bus(0, `TKC_OFS_START, 8'h00);
    chk8(d, 8'h05);
    for (int i = 0; i < 30000 && irq !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
      if (mode != 0 && !done && ref_n - base >= 100) begin
        done = 1;
        if (mode == 1) begin
          bus(1, `TKC_OFS_SWITCH, sw | 8'h20);
          base = ref_n;
          bus(1, `TKC_OFS_SWITCH, sw | 8'h20);
        end else begin
          bus(1, `TKC_OFS_START, 8'h04);
          bus(1, `TKC_OFS_START, 8'h05);
        end
      end
    end
    chk8({7'h0, irq}, 8'h01);
    chkn(ref_n - base, n, 1);
    chk8({7'h0, gat_n > g0}, 8'h01);
    g0 = gat_n;
    repeat (40) @(posedge clk_i);
    chkn(gat_n - g0, 0, 0);
    bus(0, `TKC_OFS_START, 8'h00);
    chk8(d, 8'h07);
    bus(1, `TKC_OFS_START, 8'h04);
    bus(0, `TKC_OFS_START, 8'h00);
    chk8(d, 8'h06);
  endtask

  // Whole run is near 48k cycles; a hang is stopped at 90k
  initial begin
    #720_000;
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    sys_rst_i = 1'b1;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    void'($urandom(12));
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 4; a++) begin
      bus(0, 2'(a), 8'h00);
      chk8(d, 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      sw = 8'($urandom) & 8'hdf;
      pf = 8'($urandom);
      if (i < 4) begin
        sw[1:0] = 2'(i);
        pf[3:0] = 4'hf;
      end
      bus(1, `TKC_OFS_SWITCH, sw);
      bus(1, `TKC_OFS_PADFN, pf);
      bus(1, `TKC_OFS_START, {5'h00, pf[4], 2'b00});
      @(posedge clk_i);
      #1;
      chk8({4'h0, ser_sw}, {4'h0, pf[3:0] & key_sel(sw[1:0])});
      chk8({4'h0, gnd_sw}, {4'h0, pf[3:0] & ~key_sel(sw[1:0])});
      chk8({4'h0, dig_off}, {4'h0, pf[3:0]});
      chk8({6'h0, sen_on, ref_on}, {6'h0, sw[6], sw[7]});
      chk8({6'h0, ref_sw, ref_off}, {6'h0, pf[4], pf[4]});
      bus(0, `TKC_OFS_PADFN, 8'h00);
      chk8(d, pf & 8'h0f);
      bus(0, `TKC_OFS_SWITCH, 8'h00);
      chk8(d, sw);
    end
    bus(1, `TKC_OFS_START, 8'hfa);
    bus(0, `TKC_OFS_START, 8'h00);
    chk8(d, 8'h00);
    measure(2'h0, 1);
    measure(2'h1, 2);
    measure(2'h2, 0);
    measure(2'h3, 0);
    for (int k = 0; k < 2; k++) begin
      bus(1, `TKC_OFS_SWITCH, {5'h18, k[0], 2'b00});
      repeat (10) @(posedge clk_i);
      n0 = sen_n;
      repeat (560) @(posedge clk_i);
      chkn(sen_n - n0, 80 << k, 2);
    end
    bus(1, `TKC_OFS_SWITCH, 8'h80);
    repeat (20) @(posedge clk_i);
    n0 = sen_n;
    repeat (560) @(posedge clk_i);
    chkn(sen_n - n0, 0, 0);
    final_report();
  end
endmodule
